// ### hdl/adpm_consts.vh
// constants shared by the address/data pin and strap configuration block
`ifndef ADPM_CONSTS_VH
`define ADPM_CONSTS_VH

// register byte offsets on the 8-bit register address port
`define ADPM_SYSTEM_CONTROL_REG_OFS 8'h00
`define ADPM_PPCTL_OFS 8'h04
`define ADPM_PPADDR_OFS 8'h08
`define ADPM_PPWDATA_OFS 8'h0C
`define ADPM_PPCMD_OFS 8'h10
`define ADPM_PPRDATA_OFS 8'h14
`define ADPM_FLAGVAL_OFS 8'h18
`define ADPM_FLAGDIR_OFS 8'h1C
`define ADPM_FLAGIN_OFS 8'h20
`define ADPM_STATUS_OFS 8'h24

// field positions
`define ADPM_SYSTEM_CONTROL_REG_FLAG_BIT 20
`define ADPM_PPCTL_EN_BIT 0
`define ADPM_PPCTL_W16_BIT 1
`define ADPM_CMD_START_BIT 0
`define ADPM_CMD_WRITE_BIT 1
`define ADPM_ST_BOOT_LSB 0
`define ADPM_ST_RATIO_LSB 2
`define ADPM_ST_RSVD_BIT 4
`define ADPM_ST_LOCK_BIT 5
`define ADPM_ST_BUSY_BIT 6
`define ADPM_ST_DONE_BIT 7

// reset values
`define ADPM_SYSTEM_CONTROL_REG_RST 32'h00000000
`define ADPM_PPCTL_RST 2'h0
`define ADPM_FLAG_RST 16'h0000

// boot source codes
`define ADPM_BOOT_SPI_SLAVE 2'h0
`define ADPM_BOOT_SPI_MASTER 2'h1
`define ADPM_BOOT_PAR_EPROM 2'h2
`define ADPM_BOOT_ROM_ONLY 2'h3

// core to reference clock ratio codes and multipliers
`define ADPM_RATIO_3 2'h0
`define ADPM_RATIO_16 2'h1
`define ADPM_RATIO_8 2'h2
`define ADPM_RATIO_RSVD 2'h3
`define ADPM_MULT_3 5'h03
`define ADPM_MULT_16 5'h10
`define ADPM_MULT_8 5'h08

// pin phases handed from the transfer engine to the pin mux
`define ADPM_PH_IDLE 2'h0
`define ADPM_PH_ALE 2'h1
`define ADPM_PH_DATA 2'h2

// timing
`define ADPM_LOCK_REF_CYCLES 20'h01000
`define ADPM_CLK_NS 4
`define ADPM_ALE_NS 8
`define ADPM_STROBE_NS 12
`define ADPM_RECOVER_NS 4

`endif

// ### hdl/adpm_strap_latch.v
// boot-select and core ratio strap capture and decode
`timescale 1ns/100ps
module adpm_strap_latch (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // strap pins
    input wire [1:0] boot_select_straps,
    input wire [1:0] core_ratio_straps,
    // decoded, held values
    output reg [1:0] boot_source,
    output reg [1:0] ratio_code,
    output reg [4:0] ratio_mult,
    output reg ratio_reserved,
    output reg captured
);
`include "adpm_consts.vh"

    // straps are caught on the first edge after release, never under reset
    always @(posedge core_clk) begin
        if (!rst_b) begin
            boot_source <= `ADPM_BOOT_SPI_SLAVE;
            ratio_code <= `ADPM_RATIO_3;
            ratio_mult <= `ADPM_MULT_3;
            ratio_reserved <= 1'b0;
            captured <= 1'b0;
        end else if (!captured) begin
            captured <= 1'b1;
            boot_source <= boot_select_straps;
            ratio_code <= core_ratio_straps;
            ratio_reserved <= (core_ratio_straps == `ADPM_RATIO_RSVD);
            case (core_ratio_straps)
                `ADPM_RATIO_3: ratio_mult <= `ADPM_MULT_3;
                `ADPM_RATIO_16: ratio_mult <= `ADPM_MULT_16;
                `ADPM_RATIO_8: ratio_mult <= `ADPM_MULT_8;
                // reserved code: fall back to the slowest-lock safe ratio
                default: ratio_mult <= `ADPM_MULT_16;
            endcase
        end
    end
endmodule

// ### hdl/adpm_pin_mux.v
// registered multiplexer for the address/data pins and their strobes
`timescale 1ns/100ps
module adpm_pin_mux (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // mode
    input wire flag_mode,
    input wire pp_width16,
    // transfer engine
    input wire [1:0] phase,
    input wire xfer_write,
    input wire [23:0] xfer_addr,
    input wire [15:0] xfer_wdata,
    // flag values
    input wire [15:0] flag_val,
    input wire [15:0] flag_dir,
    output reg [15:0] flag_in,
    // pins
    input wire [15:0] addr_data_pins_in,
    output reg [15:0] addr_data_pins_out,
    output reg [15:0] addr_data_pins_oe,
    output reg ale,
    output reg rd_n,
    output reg wr_n
);
`include "adpm_consts.vh"

    wire [15:0] map_out;
    wire [15:0] map_oe;
    wire [15:0] map_in;
    reg [15:0] next_out;
    reg [15:0] next_oe;

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_flag
            assign map_out[i] = flag_val[(i + 8) % 16];
            assign map_oe[i] = flag_dir[(i + 8) % 16];
            assign map_in[(i + 8) % 16] = addr_data_pins_in[i];
        end
    endgenerate

    always @* begin
        next_out = 16'h0000;
        next_oe = 16'h0000;
        if (flag_mode) begin
            next_out = map_out;
            next_oe = map_oe;
        end else if (phase == `ADPM_PH_ALE) begin
            next_oe = 16'hFFFF;
            if (pp_width16)
                next_out = xfer_addr[15:0];
            else
                next_out = xfer_addr[23:8];
        end else if (phase == `ADPM_PH_DATA) begin
            if (pp_width16) begin
                next_out = xfer_wdata;
                next_oe = xfer_write ? 16'hFFFF : 16'h0000;
            end else begin
                next_out = {xfer_addr[7:0], xfer_wdata[7:0]};
                next_oe = {8'hFF, xfer_write ? 8'hFF : 8'h00};
            end
        end
    end

    // strobes are plain flops: always driven, never released
    always @(posedge core_clk) begin
        if (!rst_b) begin
            addr_data_pins_out <= 16'h0000;
            addr_data_pins_oe <= 16'h0000;
            flag_in <= 16'h0000;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            addr_data_pins_out <= next_out;
            addr_data_pins_oe <= next_oe;
            flag_in <= flag_mode ? map_in : 16'h0000;
            ale <= !flag_mode && (phase == `ADPM_PH_ALE);
            rd_n <= !(!flag_mode && phase == `ADPM_PH_DATA && !xfer_write);
            wr_n <= !(!flag_mode && phase == `ADPM_PH_DATA && xfer_write);
        end
    end
endmodule

// ### hdl/adpm_top.v
// address/data pin, flag and strap configuration block with register port
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "adpm_consts.vh"

// Function
// - flag mode needs control bit 20, port disabled
// - pins 0-7 are flags 8-15, vice versa
// - boot straps pick SPI slave/master, EPROM, ROM
// - ratio straps give 3:1, 16:1, 8:1; 11 reserved
// - 8-bit ALE phase: A15-8 low, A23-16 high
// - 8-bit data phase: D7-0 low, A7-0 high
// - 16-bit ALE phase: A7-0 low, A15-8 high
// - 16-bit data phase: D15-0; partner latches address
// - read, write, ALE strobes always driven
// - wait 4096 reference clocks for lock
module adpm_top #(
    parameter [19:0] LOCK_REF_CYCLES = `ADPM_LOCK_REF_CYCLES
) (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // straps
    input wire [1:0] boot_select_straps,
    input wire [1:0] core_ratio_straps,
    // boot and run status
    output reg [1:0] boot_source,
    output reg core_run,
    // address/data pins
    input wire [15:0] addr_data_pins_in,
    output wire [15:0] addr_data_pins_out,
    output wire [15:0] addr_data_pins_oe,
    // parallel port strobes
    output wire ale,
    output wire rd_n,
    output wire wr_n
);

    // least times, rounded up to whole core cycles; phase counters are four bits
    localparam integer ALE_CYC_FULL =
        (`ADPM_ALE_NS + `ADPM_CLK_NS - 1) / `ADPM_CLK_NS;
    localparam integer STROBE_CYC_FULL =
        (`ADPM_STROBE_NS + `ADPM_CLK_NS - 1) / `ADPM_CLK_NS;
    localparam integer RECOVER_CYC_FULL =
        (`ADPM_RECOVER_NS + `ADPM_CLK_NS - 1) / `ADPM_CLK_NS;
    localparam [3:0] ALE_CYC = ALE_CYC_FULL[3:0];
    localparam [3:0] STROBE_CYC = STROBE_CYC_FULL[3:0];
    localparam [3:0] RECOVER_CYC = RECOVER_CYC_FULL[3:0];

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ALE = 2'h1;
    localparam [1:0] ST_STROBE = 2'h2;
    localparam [1:0] ST_RECOVER = 2'h3;

    // software state
    reg [31:0] system_control_reg;
    reg pp_enable;
    reg pp_width16;
    reg [23:0] pp_addr;
    reg [15:0] pp_wdata;
    reg [15:0] pp_rdata;
    reg [15:0] flag_val;
    reg [15:0] flag_dir;

    // transfer engine
    reg [1:0] state;
    reg [1:0] next_state;
    reg [3:0] cnt;
    reg [3:0] next_cnt;
    reg xfer_write;
    reg xfer_done;
    reg [1:0] phase;

    // lock wait
    reg [24:0] lock_cnt;
    wire [24:0] lock_target;

    // strap latch outputs
    wire [1:0] strap_boot;
    wire [1:0] strap_ratio;
    wire [4:0] strap_mult;
    wire strap_rsvd;
    wire strap_captured;

    wire [15:0] flag_in;
    wire flag_mode;
    wire start_req;
    wire [31:0] status_word;
    reg [31:0] next_rdata;

    // the port must be off before the pins can be flags
    assign flag_mode = system_control_reg[`ADPM_SYSTEM_CONTROL_REG_FLAG_BIT] && !pp_enable;

    assign start_req = reg_wr && (reg_addr == `ADPM_PPCMD_OFS)
        && reg_wdata[`ADPM_CMD_START_BIT];

    assign lock_target = {5'h00, LOCK_REF_CYCLES} * {20'h00000, strap_mult};

    adpm_strap_latch u_strap (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .boot_select_straps(boot_select_straps),
        .core_ratio_straps(core_ratio_straps),
        .boot_source(strap_boot),
        .ratio_code(strap_ratio),
        .ratio_mult(strap_mult),
        .ratio_reserved(strap_rsvd),
        .captured(strap_captured)
    );

    adpm_pin_mux u_mux (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .flag_mode(flag_mode),
        .pp_width16(pp_width16),
        .phase(phase),
        .xfer_write(xfer_write),
        .xfer_addr(pp_addr),
        .xfer_wdata(pp_wdata),
        .flag_val(flag_val),
        .flag_dir(flag_dir),
        .flag_in(flag_in),
        .addr_data_pins_in(addr_data_pins_in),
        .addr_data_pins_out(addr_data_pins_out),
        .addr_data_pins_oe(addr_data_pins_oe),
        .ale(ale),
        .rd_n(rd_n),
        .wr_n(wr_n)
    );

    // lock wait: counted in core cycles, scaled by the strapped ratio
    always @(posedge core_clk) begin
        if (!rst_b) begin
            lock_cnt <= 25'h0000000;
            core_run <= 1'b0;
            boot_source <= `ADPM_BOOT_SPI_SLAVE;
        end else begin
            boot_source <= strap_boot;
            if (strap_captured && !core_run) begin
                if (lock_cnt >= lock_target - 25'h0000001)
                    core_run <= 1'b1;
                else
                    lock_cnt <= lock_cnt + 25'h0000001;
            end
        end
    end

    // software registers
    always @(posedge core_clk) begin
        if (!rst_b) begin
            system_control_reg <= `ADPM_SYSTEM_CONTROL_REG_RST;
            pp_enable <= 1'b0;
            pp_width16 <= 1'b0;
            pp_addr <= 24'h000000;
            pp_wdata <= 16'h0000;
            flag_val <= `ADPM_FLAG_RST;
            flag_dir <= `ADPM_FLAG_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADPM_SYSTEM_CONTROL_REG_OFS:
                    system_control_reg <= reg_wdata;
                `ADPM_PPCTL_OFS: begin
                    // width changes mid-transfer would split address and data
                    if (state == ST_IDLE) begin
                        pp_enable <= reg_wdata[`ADPM_PPCTL_EN_BIT];
                        pp_width16 <= reg_wdata[`ADPM_PPCTL_W16_BIT];
                    end
                end
                `ADPM_PPADDR_OFS: begin
                    if (state == ST_IDLE)
                        pp_addr <= reg_wdata[23:0];
                end
                `ADPM_PPWDATA_OFS: begin
                    if (state == ST_IDLE)
                        pp_wdata <= reg_wdata[15:0];
                end
                `ADPM_FLAGVAL_OFS:
                    flag_val <= reg_wdata[15:0];
                `ADPM_FLAGDIR_OFS:
                    flag_dir <= reg_wdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // transfer engine: ALE phase, strobe phase, short recovery
    always @* begin
        next_state = state;
        next_cnt = cnt;
        phase = `ADPM_PH_IDLE;
        case (state)
            ST_IDLE: begin
                // no traffic before the clock has locked or in flag mode
                if (start_req && core_run && pp_enable && !flag_mode) begin
                    next_state = ST_ALE;
                    next_cnt = ALE_CYC - 4'h1;
                end
            end
            ST_ALE: begin
                phase = `ADPM_PH_ALE;
                if (cnt == 4'h0) begin
                    next_state = ST_STROBE;
                    next_cnt = STROBE_CYC - 4'h1;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_STROBE: begin
                phase = `ADPM_PH_DATA;
                if (cnt == 4'h0) begin
                    next_state = ST_RECOVER;
                    next_cnt = RECOVER_CYC - 4'h1;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ST_RECOVER: begin
                if (cnt == 4'h0)
                    next_state = ST_IDLE;
                else
                    next_cnt = cnt - 4'h1;
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = 4'h0;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            xfer_write <= 1'b0;
            xfer_done <= 1'b0;
            pp_rdata <= 16'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (state == ST_IDLE && next_state == ST_ALE) begin
                xfer_write <= reg_wdata[`ADPM_CMD_WRITE_BIT];
                xfer_done <= 1'b0;
            end
            // pins lag the engine by the mux flop, so the strobe is still
            // active at the pins on the first recovery cycle
            if (state == ST_RECOVER && cnt == RECOVER_CYC - 4'h1) begin
                xfer_done <= 1'b1;
                if (!xfer_write) begin
                    if (pp_width16)
                        pp_rdata <= addr_data_pins_in;
                    else
                        pp_rdata <= {8'h00, addr_data_pins_in[7:0]};
                end
            end
        end
    end

    assign status_word = {24'h000000,
                          xfer_done,
                          state != ST_IDLE,
                          core_run,
                          strap_rsvd,
                          strap_ratio,
                          strap_boot};

    // read mux; unmapped offsets read zero
    always @* begin
        next_rdata = 32'h00000000;
        case (reg_addr)
            `ADPM_SYSTEM_CONTROL_REG_OFS: next_rdata = system_control_reg;
            `ADPM_PPCTL_OFS: next_rdata = {30'h00000000, pp_width16, pp_enable};
            `ADPM_PPADDR_OFS: next_rdata = {8'h00, pp_addr};
            `ADPM_PPWDATA_OFS: next_rdata = {16'h0000, pp_wdata};
            `ADPM_PPCMD_OFS: next_rdata = {30'h00000000, xfer_write, state != ST_IDLE};
            `ADPM_PPRDATA_OFS: next_rdata = {16'h0000, pp_rdata};
            `ADPM_FLAGVAL_OFS: next_rdata = {16'h0000, flag_val};
            `ADPM_FLAGDIR_OFS: next_rdata = {16'h0000, flag_dir};
            `ADPM_FLAGIN_OFS: next_rdata = {16'h0000, flag_in};
            `ADPM_STATUS_OFS: next_rdata = status_word;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (!rst_b)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 32'h00000000;
    end

endmodule

// ### tb/adpm_mem_model.sv
// external address latch and parallel memory facing the pins
`timescale 1ns/100ps
module adpm_mem_model (
    // clock and mode
    input wire core_clk,
    input wire w16,
    // strobes and resolved pins
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire [15:0] pins,
    // read drive
    output wire [15:0] mem_dat,
    output wire [15:0] mem_oe
);
    reg [15:0] hi_addr = 16'h0000;
    reg [15:0] mem [0:255];
    // 8-bit mode sends the low address byte on the high pins during data
    wire [7:0] idx = w16 ? hi_addr[7:0] : pins[15:8];
    always @(posedge core_clk) begin
        if (ale)
            hi_addr <= pins;
        if (!wr_n)
            mem[idx] <= w16 ? pins : {8'h00, pins[7:0]};
    end
    // released lines fall back to the pull-up in the bench
    assign mem_oe = rd_n ? 16'h0000 : (w16 ? 16'hFFFF : 16'h00FF);
    // a continuous read follows writes to the word already addressed
    assign mem_dat = mem[idx];
endmodule

// ### tb/adpm_top_assertions.sv
// concurrent checks on the pin block's ports
`timescale 1ns/100ps
module adpm_checker #(
    parameter [19:0] LOCK_REF_CYCLES = 20'h01000
) (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // status
    input wire [1:0] boot_source,
    input wire core_run,
    // pins and strobes
    input wire [15:0] addr_data_pins_out,
    input wire [15:0] addr_data_pins_oe,
    input wire ale,
    input wire rd_n,
    input wire wr_n
);
    reg [15:0] run_cnt;
    always @(posedge core_clk) begin
        if (!rst_b)
            run_cnt <= 16'h0000;
        else if (run_cnt != 16'hFFFF)
            run_cnt <= run_cnt + 16'h0001;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_ale;
        ale [*2];
    endsequence
    sequence s_strobe;
        (!ale && !(rd_n && wr_n)) [*3] ##1 (!ale && rd_n && wr_n);
    endsequence
    property p_frame;
        $rose(ale) |-> s_ale ##1 s_strobe;
    endproperty
    a_frame: assert property (p_frame) else $error("bad transfer framing");
    property p_excl;
        !(!rd_n && !wr_n) && !(ale && !(rd_n && wr_n));
    endproperty
    a_excl: assert property (p_excl) else $error("strobes overlap");
    property p_ale_oe;
        ale |-> addr_data_pins_oe == 16'hFFFF;
    endproperty
    a_ale_oe: assert property (p_ale_oe) else $error("address not driven");
    property p_ale_hold;
        ale && $past(ale) |-> $stable(addr_data_pins_out);
    endproperty
    a_ale_hold: assert property (p_ale_hold) else $error("address moved");
    property p_rd_oe;
        !rd_n |-> addr_data_pins_oe[7:0] == 8'h00;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("data pins driven on read");
    property p_wr_oe;
        !wr_n |-> addr_data_pins_oe == 16'hFFFF;
    endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("data pins released on write");
    property p_lock;
        $rose(core_run) |-> run_cnt >= 3 * LOCK_REF_CYCLES - 2
            && run_cnt <= 16 * LOCK_REF_CYCLES + 8;
    endproperty
    a_lock: assert property (p_lock) else $error("lock wait wrong");
    property p_run_hold;
        core_run |=> core_run;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("core run dropped");
    property p_strap;
        $past(rst_b) && $past(rst_b, 2) && $past(rst_b, 3) |-> $stable(boot_source);
    endproperty
    a_strap: assert property (p_strap) else $error("boot source moved");
endmodule
bind adpm_top adpm_checker #(.LOCK_REF_CYCLES(LOCK_REF_CYCLES)) u_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .boot_source(boot_source),
    .core_run(core_run),
    .addr_data_pins_out(addr_data_pins_out),
    .addr_data_pins_oe(addr_data_pins_oe),
    .ale(ale),
    .rd_n(rd_n),
    .wr_n(wr_n)
);

// ### tb/adpm_top_test.sv
// self-checking bench for the address/data pin block
`timescale 1ns/100ps
`include "adpm_consts.vh"
module adpm_top_test;
    localparam [19:0] LOCK = 20'h00008;
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [1:0] boot_select_straps = 2'h0;
    reg [1:0] core_ratio_straps = 2'h0;
    reg w16 = 1'b0;
    reg tb_oe = 1'b0;
    reg [15:0] tb_val = 16'h0000;
    wire [31:0] reg_rdata;
    wire [1:0] boot_source;
    wire core_run;
    wire [15:0] pins_in, pins_out, pins_oe, mem_dat, mem_oe;
    wire ale, rd_n, wr_n;
    integer error_cnt = 0;
    integer checked = 0;
    // undriven pins float to the pull-up
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & mem_oe & mem_dat)
        | (~pins_oe & ~mem_oe & (tb_oe ? tb_val : 16'hFFFF));
    adpm_top #(.LOCK_REF_CYCLES(LOCK)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .boot_select_straps(boot_select_straps),
        .core_ratio_straps(core_ratio_straps), .boot_source(boot_source),
        .core_run(core_run), .addr_data_pins_in(pins_in), .addr_data_pins_out(pins_out),
        .addr_data_pins_oe(pins_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
    adpm_mem_model mem (.core_clk(core_clk), .w16(w16), .ale(ale), .rd_n(rd_n),
        .wr_n(wr_n), .pins(pins_in), .mem_dat(mem_dat), .mem_oe(mem_oe));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task t_straps(input [1:0] b, input [1:0] r, input [7:0] mult);
        integer n;
        reg [31:0] v;
        begin
            @(posedge core_clk);
            rst_b <= 1'b0;
            boot_select_straps <= b;
            core_ratio_straps <= r;
            repeat (6) @(posedge core_clk);
            rst_b <= 1'b1;
            @(posedge core_clk);
            // later strap changes must not leak through
            boot_select_straps <= ~b;
            core_ratio_straps <= ~r;
            n = 0;
            while (core_run !== 1'b1 && n < 300) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            chk({31'h0, n >= LOCK * mult - 2 && n <= LOCK * mult + 4}, 32'h1);
            chk({30'h0, boot_source}, {30'h0, b});
            rd(`ADPM_STATUS_OFS, v);
            chk({27'h0, v[4:0]}, {27'h0, r == 2'h3, r, b});
        end
    endtask
    task t_flags;
        reg [31:0] v;
        begin
            wr(`ADPM_PPCTL_OFS, 32'h1);
            wr(`ADPM_SYSTEM_CONTROL_REG_OFS, 32'h1 << `ADPM_SYSTEM_CONTROL_REG_FLAG_BIT);
            wr(`ADPM_FLAGDIR_OFS, 32'hFFFF);
            wr(`ADPM_FLAGVAL_OFS, 32'h12C4);
            repeat (2) @(posedge core_clk);
            #1 chk({16'h0, pins_oe}, 32'h0);
            wr(`ADPM_PPCTL_OFS, 32'h0);
            repeat (2) @(posedge core_clk);
            #1 chk({16'h0, pins_oe}, 32'hFFFF);
            chk({16'h0, pins_out}, 32'hC412);
            wr(`ADPM_FLAGDIR_OFS, 32'h0);
            tb_oe <= 1'b1;
            tb_val <= 16'h5A3C;
            repeat (3) @(posedge core_clk);
            rd(`ADPM_FLAGIN_OFS, v);
            chk(v, 32'h3C5A);
            wr(`ADPM_SYSTEM_CONTROL_REG_OFS, 32'h0);
            tb_oe <= 1'b0;
            rd(8'hFC, v);
            chk(v, 32'h0);
        end
    endtask
    task t_xfer(input wide, input wrt, input [23:0] a, input [15:0] d);
        reg [15:0] av, dv, ov;
        reg [31:0] v;
        integer n;
        begin
            av = wide ? a[15:0] : a[23:8];
            dv = wide ? d : {a[7:0], d[7:0]};
            ov = wrt ? 16'hFFFF : (wide ? 16'h0000 : 16'hFF00);
            w16 <= wide;
            wr(`ADPM_PPCTL_OFS, {30'h0, wide, 1'b1});
            wr(`ADPM_PPADDR_OFS, {8'h0, a});
            wr(`ADPM_PPWDATA_OFS, {16'h0, d});
            wr(`ADPM_PPCMD_OFS, {30'h0, wrt, 1'b1});
            n = 0;
            while (ale !== 1'b1 && n < 20) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            chk({16'h0, pins_out}, {16'h0, av});
            while (ale === 1'b1 && n < 40) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            chk({16'h0, pins_oe}, {16'h0, ov});
            chk({16'h0, pins_out & ov}, {16'h0, dv & ov});
            while (!(rd_n === 1'b1 && wr_n === 1'b1) && n < 60) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
            rd(`ADPM_STATUS_OFS, v);
            chk({30'h0, v[7:6]}, 32'h2);
            if (wrt)
                chk({16'h0, mem.hi_addr}, {16'h0, av});
            else begin
                rd(`ADPM_PPRDATA_OFS, v);
                chk(v, wide ? {16'h0, d} : {24'h0, d[7:0]});
            end
        end
    endtask
    task wrap_up;
        begin
            if (error_cnt == 0 && checked > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        #40000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end
    initial begin
        t_straps(2'h3, 2'h3, 8'd16);
        t_straps(2'h0, 2'h0, 8'd3);
        t_straps(2'h1, 2'h1, 8'd16);
        t_straps(2'h2, 2'h2, 8'd8);
        t_flags;
        t_xfer(1'b0, 1'b1, 24'hA1B2C3, 16'h5E6F);
        t_xfer(1'b0, 1'b0, 24'hA1B2C3, 16'h5E6F);
        t_xfer(1'b1, 1'b1, 24'h0F1E2D, 16'h9C8B);
        t_xfer(1'b1, 1'b0, 24'h0F1E2D, 16'h9C8B);
        wrap_up;
    end
endmodule
